// ---- gpc_port.v ----
// eight-bit gpio port with pull-ups, change detection and axi4-lite registers
`timescale 1ns/1ps
`include "gpc_consts.vh"

// Functional notes
// - eight-bit two-way port, one direction bit per pin in direction register.
// - direction bit one puts that pin's driver in high impedance.
// - direction bit zero drives the pin from its output latch bit.
// - data read returns pin levels; data write goes to the latch only.
// - every port write is read-modify-write using sampled pin levels.
// - clearing active-low pull-up bit 7 of option enables the pull-ups of all input pins.
// - a pin set as output never has its pull-up enabled.
// - after power-on reset all pull-ups are off.
// - only inputs among pins 7 to 4 take part in change detection.
// - mismatch against last-read value, ORed, sets change flag at bit 0.
// - pending change interrupt wakes the device from sleep.
// - any port read or write recaptures the compare value.
// - flag keeps setting while mismatch persists; set beats software clear.
// - a change exactly at the read sample may miss setting the flag.
// - flags set regardless of individual enable and global enable bit 7.
module gpc_port (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  pin_in,
  output wire [7:0]  pin_out,
  output wire [7:0]  pin_oe_n,
  output wire [7:0]  pullup_on,
  output wire        core_irq,
  output wire        wake,
  output wire        sleeping,
  output wire        irq
);

  // ==========================================================
  // state
  reg  [7:0] pin_meta_q;
  reg  [7:0] pin_sync_q;
  reg  [7:0] port_latch_q;
  reg  [7:0] port_direction_q;
  reg  [7:0] option_q;
  reg  [7:0] intctl_q;
  reg  [7:0] compare_q;
  reg  [1:0] stat_q;
  reg  [1:0] mask_q;
  reg        sleep_q;
  reg  [4:0] aw_q;
  reg        aw_full_q;
  reg  [31:0] w_q;
  reg  [3:0] ws_q;
  reg        w_full_q;

  wire       wr_go;
  wire       rd_go;
  wire [7:0] mismatch;
  wire       chg_now;
  wire       wake_ev;
  wire [7:0] wbyte;
  wire       port_touch;

  // merge write data lane 0 into an old value
  function [7:0] merge_lane;
    input [7:0] old;
    input [7:0] nw;
    input       en;
    begin
      merge_lane = en ? nw : old;
    end
  endfunction

  // ==========================================================
  // pin drivers
  assign pin_out   = port_latch_q;
  assign pin_oe_n  = port_direction_q;
  assign pullup_on = ~port_direction_q &
                     {8{1'b0}} |
                     (port_direction_q & {8{~option_q[`GPC_BIT_PULLUP_N]}});

  // ==========================================================
  // change detection
  assign mismatch = (pin_sync_q ^ compare_q) & port_direction_q &
                    `GPC_CHG_MASK;
  assign chg_now  = |mismatch;
  assign wake_ev  = sleep_q & intctl_q[`GPC_BIT_CHG_FLAG] &
                    intctl_q[`GPC_BIT_CHG_IE];
  assign wake     = wake_ev;
  assign sleeping = sleep_q;
  assign core_irq = intctl_q[`GPC_BIT_CHG_FLAG] & intctl_q[`GPC_BIT_CHG_IE] &
                    intctl_q[`GPC_BIT_GIE];
  assign irq      = |(stat_q & mask_q);

  // ==========================================================
  // axi4-lite handshakes
  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid & clk_en;
  assign rd_go = s_axi_arvalid & s_axi_arready & clk_en;
  assign wbyte = w_q[7:0];
  assign port_touch = (wr_go & (aw_q == `GPC_OFF_DATA)) |
                      (rd_go & (s_axi_araddr == `GPC_OFF_DATA));

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_q       <= 8'h00;
      pin_sync_q       <= 8'h00;
      port_latch_q     <= `GPC_RST_LATCH;
      port_direction_q <= `GPC_RST_DIR;
      option_q         <= `GPC_RST_OPTION;
      intctl_q         <= `GPC_RST_INTCTL;
      compare_q        <= 8'h00;
      stat_q           <= 2'h0;
      mask_q           <= `GPC_RST_MASK;
      sleep_q          <= 1'b0;
      aw_q             <= 5'h00;
      aw_full_q        <= 1'b0;
      w_q              <= 32'h0000_0000;
      ws_q             <= 4'h0;
      w_full_q         <= 1'b0;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= `GPC_RESP_OKAY;
      s_axi_rvalid     <= 1'b0;
      s_axi_rresp      <= `GPC_RESP_OKAY;
      s_axi_rdata      <= 32'h0000_0000;
    end else if (clk_en) begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
      // capture channels
      if (s_axi_awvalid & s_axi_awready) begin
        aw_q      <= s_axi_awaddr;
        aw_full_q <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_q      <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
        w_full_q <= 1'b1;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      // ==========================================================
      // register writes
      if (wr_go) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `GPC_RESP_OKAY;
        case (aw_q)
          `GPC_OFF_DATA:
            port_latch_q <= merge_lane(pin_sync_q, wbyte, ws_q[0]);
          `GPC_OFF_DIR:
            port_direction_q <= merge_lane(port_direction_q, wbyte, ws_q[0]);
          `GPC_OFF_OPTION:
            option_q <= merge_lane(option_q, wbyte, ws_q[0]);
          `GPC_OFF_INTCTL:
            intctl_q <= merge_lane(intctl_q, wbyte, ws_q[0]);
          `GPC_OFF_IRQ_STAT:
            if (ws_q[0])
              stat_q <= stat_q & ~wbyte[1:0];
          `GPC_OFF_IRQ_MASK:
            mask_q <= ws_q[0] ? wbyte[1:0] : mask_q;
          `GPC_OFF_CTRL:
            if (ws_q[0])
              sleep_q <= wbyte[`GPC_BIT_SLEEP];
          default:
            s_axi_bresp <= `GPC_RESP_SLVERR;
        endcase
      end
      // ==========================================================
      // register reads
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `GPC_RESP_OKAY;
        case (s_axi_araddr)
          `GPC_OFF_DATA:      s_axi_rdata <= {24'h0, pin_sync_q};
          `GPC_OFF_DIR:       s_axi_rdata <= {24'h0, port_direction_q};
          `GPC_OFF_OPTION:    s_axi_rdata <= {24'h0, option_q};
          `GPC_OFF_INTCTL:    s_axi_rdata <= {24'h0, intctl_q};
          `GPC_OFF_IRQ_STAT:  s_axi_rdata <= {30'h0, stat_q};
          `GPC_OFF_IRQ_MASK:  s_axi_rdata <= {30'h0, mask_q};
          `GPC_OFF_CTRL:      s_axi_rdata <= {31'h0, sleep_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `GPC_RESP_SLVERR;
          end
        endcase
      end
      // ==========================================================
      // compare value, flags and sleep
      if (port_touch)
        compare_q <= pin_sync_q;
      if (chg_now & ~port_touch)
        intctl_q[`GPC_BIT_CHG_FLAG] <= 1'b1;
      if (chg_now & ~port_touch)
        stat_q[`GPC_BIT_EV_CHG] <= 1'b1;
      if (wake_ev) begin
        sleep_q                <= 1'b0;
        stat_q[`GPC_BIT_EV_WAKE] <= 1'b1;
      end
    end
  end

endmodule // gpc_port

// ---- gpc_consts.vh ----
// register map, field positions and reset values for the gpio change port
`ifndef GPC_CONSTS_VH
`define GPC_CONSTS_VH
// ==========================================================
// register byte offsets
`define GPC_OFF_DATA      5'h00
`define GPC_OFF_DIR       5'h04
`define GPC_OFF_OPTION    5'h08
`define GPC_OFF_INTCTL    5'h0c
`define GPC_OFF_IRQ_STAT  5'h10
`define GPC_OFF_IRQ_MASK  5'h14
`define GPC_OFF_CTRL      5'h18
// ==========================================================
// field positions
`define GPC_BIT_PULLUP_N  7
`define GPC_BIT_GIE       7
`define GPC_BIT_CHG_IE    3
`define GPC_BIT_CHG_FLAG  0
`define GPC_BIT_SLEEP     0
`define GPC_BIT_EV_CHG    0
`define GPC_BIT_EV_WAKE   1
// ==========================================================
// reset values
`define GPC_RST_DIR       8'hff
`define GPC_RST_LATCH     8'h00
`define GPC_RST_OPTION    8'hff
`define GPC_RST_INTCTL    8'h00
`define GPC_RST_MASK      2'h0
// upper pins that take part in change detection
`define GPC_CHG_MASK      8'hf0
// axi responses
`define GPC_RESP_OKAY     2'h0
`define GPC_RESP_SLVERR   2'h2
`endif

// ---- gpc_port_properties.sv ----
// concurrent checks on the gpio change port
`timescale 1ns/1ps
module gpc_port_checker (
  input logic       clk_sys,
  input logic       sys_rst,
  input logic       s_axi_arvalid,
  input logic       s_axi_arready,
  input logic       s_axi_rvalid,
  input logic       s_axi_rready,
  input logic       s_axi_bvalid,
  input logic       s_axi_bready,
  input logic [7:0] pin_oe_n,
  input logic [7:0] pullup_on,
  input logic       core_irq,
  input logic       wake,
  input logic       sleeping,
  input logic       irq
);
  // ==========================================================
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  pullup_out_a: assert property (!(|(pullup_on & ~pin_oe_n)))
    else $error("pull-up on driven pin");
  pullup_all_a: assert property (pullup_on == 8'h00 || pullup_on == pin_oe_n)
    else $error("pull-ups not uniform");
  pullup_rst_a: assert property ($fell(sys_rst) |-> pullup_on == 8'h00)
    else $error("pull-up on after reset");
  wake_sleep_a: assert property (wake |-> sleeping)
    else $error("wake while awake");
  wake_clear_a: assert property (wake |=> !sleeping)
    else $error("sleep kept after wake");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  cover property (core_irq);
  cover property (wake);
  cover property (irq);
endmodule // gpc_port_checker
bind gpc_port gpc_port_checker u_chk (.*);

// ---- gpc_pins_model.sv ----
// external pins: switches, weak pull-ups and floating lines
`timescale 1ns/1ps
module gpc_pins_model (
  input  logic       clk_sys,
  input  logic [7:0] pin_out,
  input  logic [7:0] pin_oe_n,
  input  logic [7:0] pullup_on,
  input  logic [7:0] ext_en,
  input  logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // ==========================================================
  // wire level
  logic [7:0] float_q = 8'h55;
  always @(posedge clk_sys) float_q <= ~float_q;
  always_comb
    for (int i = 0; i < 8; i++)
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pullup_on[i] ? 1'b1 : float_q[i];
endmodule // gpc_pins_model

// ---- gpio_port_with_change_interrupt_tb_top.sv ----
// self-checking bench for the gpio change port
`timescale 1ns/1ps
`include "gpc_consts.vh"
module gpio_port_with_change_interrupt_tb_top;
  // ==========================================================
  // signals
  logic        clk_sys = 1'b0, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, rdv;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [7:0]  ext_en = 8'hff, ext_val = 8'ha5;
  logic        clk_en = 1'b1;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [7:0]  pin_in, pin_out, pin_oe_n, pullup_on;
  wire         core_irq, wake, sleeping, irq;
  int          errors = 0, cmp_count = 0, n;
  gpc_port dut (.*);
  gpc_pins_model pins (.*);
  initial forever #50 clk_sys = ~clk_sys;
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang;
    if (n >= 40) begin
      $display("Error wait expected done seen timeout");
      errors++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic aw_hit, w_hit, b_hit;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    b_hit = 1'b0;
    while (!b_hit && n < 40) begin
      @(negedge clk_sys);
      n++;
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid;
      @(posedge clk_sys);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (b_hit) n = 0;
    hang();
  endtask
  task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic ar_hit, r_hit;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    r_hit = 1'b0;
    while (!r_hit && n < 40) begin
      @(negedge clk_sys);
      n++;
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid;
      rdv = s_axi_rdata;
      @(posedge clk_sys);
      if (ar_hit) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (r_hit) n = 0;
    hang();
    chk(nm, e, rdv);
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk("pullup_on", 32'h0, {24'h0, pullup_on});
    chk("pin_oe_n", 32'hff, {24'h0, pin_oe_n});
    rc("direction", `GPC_OFF_DIR, 32'hff);
    rc("option", `GPC_OFF_OPTION, 32'hff);
    ext_en <= 8'h00;
    wr(`GPC_OFF_OPTION, 8'h7f);
    chk("pullup_on", 32'hff, {24'h0, pullup_on});
    wr(`GPC_OFF_DIR, 8'hf0);
    chk("pullup_on", 32'hf0, {24'h0, pullup_on});
    wr(`GPC_OFF_DATA, 8'h3c);
    chk("pin_out", 32'h3c, {24'h0, pin_out});
    rc("data", `GPC_OFF_DATA, 32'hfc);
    $display("test port done");
    wr(`GPC_OFF_INTCTL, 8'h00);
    rc("intctl", `GPC_OFF_INTCTL, 32'h0);
    ext_en <= 8'h10;
    ext_val <= 8'h00;
    repeat (4) @(posedge clk_sys);
    rc("intctl", `GPC_OFF_INTCTL, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`GPC_OFF_INTCTL, 8'h00);
    rc("intctl", `GPC_OFF_INTCTL, 32'h1);
    rc("data", `GPC_OFF_DATA, 32'hec);
    wr(`GPC_OFF_INTCTL, 8'h00);
    wr(`GPC_OFF_DIR, 8'hff);
    repeat (4) @(posedge clk_sys);
    rc("intctl", `GPC_OFF_INTCTL, 32'h0);
    $display("test change done");
    wr(`GPC_OFF_IRQ_MASK, 8'h03);
    wr(`GPC_OFF_CTRL, 8'h01);
    wr(`GPC_OFF_INTCTL, 8'h88);
    ext_en <= 8'h30;
    n = 0;
    while (sleeping !== 1'b0 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    hang();
    chk("core_irq", 32'h1, {31'h0, core_irq});
    chk("irq", 32'h1, {31'h0, irq});
    rc("irq_stat", `GPC_OFF_IRQ_STAT, 32'h3);
    wr(`GPC_OFF_INTCTL, 8'h80);
    chk("core_irq", 32'h0, {31'h0, core_irq});
    rc("data", `GPC_OFF_DATA, 32'hcf);
    wr(`GPC_OFF_IRQ_STAT, 8'h03);
    chk("irq", 32'h0, {31'h0, irq});
    clk_en <= 1'b0;
    ext_en <= 8'h00;
    repeat (6) @(posedge clk_sys);
    chk("irq_frozen", 32'h0, {31'h0, irq});
    clk_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("irq_thawed", 32'h1, {31'h0, irq});
    rc("unmapped", 5'h1c, 32'h0);
    chk("rresp", {30'h0, `GPC_RESP_SLVERR}, {30'h0, s_axi_rresp});
    $display("test interrupt done");
    complete_run();
  end
endmodule // gpio_port_with_change_interrupt_tb_top
